// [common/cpuij_pkg.sv]
// Shared constants, types and decode helper for the small core's execute block
package cpuij_pkg;

    localparam int IW = 14;
    localparam int DW = 8;
    localparam int PCW = 13;
    localparam int FAW = 7;
    localparam int BAW = 8;
    localparam int TGW = 11;

    // Instruction word fields
    localparam int DEST_BIT = 7;
    localparam int OPC6_LSB = 8;
    localparam int OPC3_LSB = 11;
    localparam int LATCH_HI_MSB = 4;
    localparam int LATCH_HI_LSB = 3;

    // Opcode encodings
    localparam logic [5:0] OPC_OR_ACC_REG = 6'h04;
    localparam logic [5:0] OPC_MOVE_REG = 6'h08;
    localparam logic [5:0] OPC_INCR_REG = 6'h0a;
    localparam logic [5:0] OPC_INCR_SKIP = 6'h0f;
    localparam logic [5:0] OPC_OR_LIT = 6'h38;
    localparam logic [2:0] OPC_JUMP = 3'h5;
    localparam logic [IW-1:0] INSTR_NO_OPERATION = 14'h0000;

    // Register port map; file registers occupy 8'h00 to 8'h7f
    localparam logic [BAW-1:0] ADDR_ACC = 8'h80;
    localparam logic [BAW-1:0] ADDR_STATUS = 8'h81;
    localparam logic [BAW-1:0] ADDR_PC_LATCH = 8'h82;
    localparam logic [BAW-1:0] ADDR_PC_LOW = 8'h83;
    localparam logic [BAW-1:0] ADDR_PC_HIGH = 8'h84;
    localparam logic [BAW-1:0] ADDR_CTRL = 8'h85;
    localparam int FILE_SEL_BIT = 7;
    localparam int STATUS_Z_BIT = 0;
    localparam int CTRL_RUN_BIT = 0;

    // Reset values
    localparam logic [DW-1:0] RST_ACC = 8'h00;
    localparam logic RST_ZERO = 1'b0;
    localparam logic [DW-1:0] RST_PC_LATCH = 8'h00;
    localparam logic [DW-1:0] RST_CTRL = 8'h01;
    localparam logic [PCW-1:0] RST_PC = 13'h0000;

    typedef enum logic [2:0] {
        CPUIJ_OP_NONE      = 3'b000,
        CPUIJ_OP_INCR_SKIP = 3'b001,
        CPUIJ_OP_JUMP      = 3'b010,
        CPUIJ_OP_OR_LIT    = 3'b011,
        CPUIJ_OP_INCR      = 3'b100,
        CPUIJ_OP_OR_REG    = 3'b101,
        CPUIJ_OP_MOVE      = 3'b110
    } cpuij_op_t;

    typedef struct packed {
        cpuij_op_t op;
        logic [DW-1:0] result;
        logic to_acc;
        logic to_file;
        logic upd_z;
        logic skip;
        logic jump;
        logic [TGW-1:0] target;
    } cpuij_exec_t;

    typedef struct packed {
        logic [BAW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } cpuij_bus_t;

    function automatic cpuij_op_t cpuij_op_of(input logic [IW-1:0] w);
        cpuij_op_t op;
        op = CPUIJ_OP_NONE;
        if (w[IW-1:OPC3_LSB] == OPC_JUMP) begin
            op = CPUIJ_OP_JUMP;
        end else begin
            case (w[IW-1:OPC6_LSB])
                OPC_INCR_SKIP: op = CPUIJ_OP_INCR_SKIP;
                OPC_OR_LIT: op = CPUIJ_OP_OR_LIT;
                OPC_INCR_REG: op = CPUIJ_OP_INCR;
                OPC_OR_ACC_REG: op = CPUIJ_OP_OR_REG;
                OPC_MOVE_REG: op = CPUIJ_OP_MOVE;
                default: op = CPUIJ_OP_NONE;
            endcase
        end
        return op;
    endfunction

endpackage

// [core/cpuij_decode.sv]
// Combinational decode and arithmetic for one instruction word
`timescale 1ns/10ps
module cpuij_decode (
    input wire logic [cpuij_pkg::IW-1:0] instr,
    input wire logic [cpuij_pkg::DW-1:0] acc,
    input wire logic [cpuij_pkg::DW-1:0] fval,
    output cpuij_pkg::cpuij_exec_t dec
);
    import cpuij_pkg::*;

    logic [DW-1:0] inc_val;
    logic dest_file;

    assign inc_val = fval + 8'h01;
    assign dest_file = instr[DEST_BIT];

    always_comb begin
        dec = '0;
        dec.op = cpuij_op_of(instr);
        dec.target = instr[TGW-1:0];
        case (dec.op)
            CPUIJ_OP_INCR_SKIP: begin
                dec.result = inc_val;
                dec.to_acc = !dest_file;
                dec.to_file = dest_file;
                dec.skip = (inc_val == 8'h00);
            end
            CPUIJ_OP_JUMP: begin
                dec.jump = 1'b1;
            end
            CPUIJ_OP_OR_LIT: begin
                dec.result = acc | instr[DW-1:0];
                dec.to_acc = 1'b1;
                dec.upd_z = 1'b1;
            end
            CPUIJ_OP_INCR: begin
                dec.result = inc_val;
                dec.to_acc = !dest_file;
                dec.to_file = dest_file;
                dec.upd_z = 1'b1;
            end
            CPUIJ_OP_OR_REG: begin
                dec.result = acc | fval;
                dec.to_acc = !dest_file;
                dec.to_file = dest_file;
                dec.upd_z = 1'b1;
            end
            CPUIJ_OP_MOVE: begin
                // Writing back to itself still refreshes the zero flag
                dec.result = fval;
                dec.to_acc = !dest_file;
                dec.to_file = dest_file;
                dec.upd_z = 1'b1;
            end
            default: begin
                dec.op = CPUIJ_OP_NONE;
            end
        endcase
    end

endmodule // cpuij_decode

// [core/cpuij_core.sv]
// Execute block of the small 8-bit core: fetch, skip, jump, accumulator and file
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps

// What this block does
// - Increment-skip adds one, d selects destination
// - Zero result flushes next word as no-op
// - Jump loads eleven-bit target into low PC
// - Jump fills PC 12:11 from latch 4:3
// - Jump takes two cycles, flushing fetched word
// - Or-literal ORs immediate into accumulator
// - Increment adds one, d selects destination
// - Or-register ORs accumulator with file register
// - Move copies register to accumulator or itself
// - Move updates zero flag from moved value
module cpuij_core (
    input wire logic clk_sys,
    input wire logic rst_n,
    input cpuij_pkg::cpuij_bus_t bus,
    output logic [cpuij_pkg::DW-1:0] bus_rdata,
    input wire logic [cpuij_pkg::IW-1:0] prog_data,
    output logic [cpuij_pkg::PCW-1:0] prog_addr,
    output logic [cpuij_pkg::DW-1:0] acc_out,
    output logic zero_out
);
    import cpuij_pkg::*;

    logic [PCW-1:0] pc_r;
    logic [IW-1:0] ir_r;
    logic flush_r;
    logic [DW-1:0] acc_r;
    logic zero_r;
    logic [DW-1:0] latch_r;
    logic [DW-1:0] ctrl_r;
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] file_mem [0:(1<<FAW)-1];
    logic [FAW-1:0] faddr;
    logic [DW-1:0] fval;
    logic run;
    logic exec_en;
    logic bus_file;
    cpuij_exec_t dec;

    assign run = ctrl_r[CTRL_RUN_BIT];
    // A flushed slot executes as no_operation
    assign exec_en = run && !flush_r;
    assign faddr = ir_r[FAW-1:0];
    assign fval = file_mem[faddr];
    assign bus_file = !bus.addr[FILE_SEL_BIT];

    cpuij_decode u_decode (
        .instr(ir_r),
        .acc(acc_r),
        .fval(fval),
        .dec(dec)
    );

    // Fetch: the word presented at pc_r is latched for execution next cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc_r <= RST_PC;
            ir_r <= INSTR_NO_OPERATION;
            flush_r <= 1'b1;
        end else if (run) begin
            ir_r <= prog_data;
            if (exec_en && dec.jump) begin
                pc_r <= {latch_r[LATCH_HI_MSB:LATCH_HI_LSB], dec.target};
                flush_r <= 1'b1;
            end else begin
                pc_r <= pc_r + 13'h0001;
                flush_r <= exec_en && dec.skip;
            end
        end
    end

    // Core write wins over a register-port write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_r <= RST_ACC;
        end else if (exec_en && dec.to_acc) begin
            acc_r <= dec.result;
        end else if (bus.wr && bus.addr == ADDR_ACC) begin
            acc_r <= bus.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            zero_r <= RST_ZERO;
        end else if (exec_en && dec.upd_z) begin
            zero_r <= (dec.result == 8'h00);
        end else if (bus.wr && bus.addr == ADDR_STATUS) begin
            zero_r <= bus.wdata[STATUS_Z_BIT];
        end
    end

    // File array is memory and holds no reset value
    always_ff @(posedge clk_sys) begin
        if (exec_en && dec.to_file) begin
            file_mem[faddr] <= dec.result;
        end else if (bus.wr && bus_file) begin
            file_mem[bus.addr[FAW-1:0]] <= bus.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            latch_r <= RST_PC_LATCH;
        end else if (bus.wr && bus.addr == ADDR_PC_LATCH) begin
            latch_r <= bus.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r <= RST_CTRL;
        end else if (bus.wr && bus.addr == ADDR_CTRL) begin
            ctrl_r <= bus.wdata;
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            if (bus_file) begin
                rdata_r <= file_mem[bus.addr[FAW-1:0]];
            end else begin
                case (bus.addr)
                    ADDR_ACC: rdata_r <= acc_r;
                    ADDR_STATUS: rdata_r <= {7'h00, zero_r};
                    ADDR_PC_LATCH: rdata_r <= latch_r;
                    ADDR_PC_LOW: rdata_r <= pc_r[DW-1:0];
                    ADDR_PC_HIGH: rdata_r <= {3'h0, pc_r[PCW-1:DW]};
                    ADDR_CTRL: rdata_r <= ctrl_r;
                    default: rdata_r <= 8'h00;
                endcase
            end
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign bus_rdata = rdata_r;
    assign prog_addr = pc_r;
    assign acc_out = acc_r;
    assign zero_out = zero_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic ex_skip;
    logic ex_jump;
    logic ex_simple;
    assign ex_skip = exec_en && dec.op == CPUIJ_OP_INCR_SKIP;
    assign ex_jump = exec_en && dec.op == CPUIJ_OP_JUMP;
    assign ex_simple = exec_en && (dec.op == CPUIJ_OP_OR_LIT || dec.op == CPUIJ_OP_INCR
        || dec.op == CPUIJ_OP_OR_REG || dec.op == CPUIJ_OP_MOVE);

    chk_skip_file_write: assert property (
        ex_skip && ir_r[DEST_BIT]
        |=> file_mem[$past(faddr)] == $past(fval) + 8'h01)
        else $error("increment-skip did not write file register");

    chk_skip_zero_flush: assert property (
        ex_skip && fval == 8'hff |=> flush_r ##1 !flush_r || !run)
        else $error("zero result did not flush exactly one word");

    chk_skip_nonzero_run: assert property (
        ex_skip && fval != 8'hff |=> !flush_r)
        else $error("nonzero increment-skip flushed next word");

    chk_jump_low_bits: assert property (
        ex_jump |=> pc_r[TGW-1:0] == $past(ir_r[TGW-1:0]))
        else $error("jump target not loaded into low program counter");

    chk_jump_high_bits: assert property (
        ex_jump |=> pc_r[PCW-1:TGW] == $past(latch_r[LATCH_HI_MSB:LATCH_HI_LSB]))
        else $error("jump high bits not taken from latch");

    chk_jump_two_cycles: assert property (
        ex_jump |=> flush_r && !exec_en)
        else $error("jump did not flush the fetched word");

    chk_or_literal_acc: assert property (
        exec_en && dec.op == CPUIJ_OP_OR_LIT
        |=> acc_r == ($past(acc_r) | $past(ir_r[DW-1:0])))
        else $error("or-literal result wrong");

    chk_incr_acc_dest: assert property (
        exec_en && dec.op == CPUIJ_OP_INCR && !ir_r[DEST_BIT]
        |=> acc_r == $past(fval) + 8'h01)
        else $error("increment to accumulator wrong");

    chk_or_reg_acc: assert property (
        exec_en && dec.op == CPUIJ_OP_OR_REG && !ir_r[DEST_BIT]
        |=> acc_r == ($past(acc_r) | $past(fval)))
        else $error("or-register to accumulator wrong");

    chk_move_acc: assert property (
        exec_en && dec.op == CPUIJ_OP_MOVE && !ir_r[DEST_BIT] |=> acc_r == $past(fval))
        else $error("move to accumulator wrong");

    chk_move_zero_flag: assert property (
        exec_en && dec.op == CPUIJ_OP_MOVE |=> zero_r == ($past(fval) == 8'h00))
        else $error("move did not update zero flag");

    chk_flags_kept: assert property (
        (ex_skip || ex_jump) && !(bus.wr && bus.addr == ADDR_STATUS) |=> $stable(zero_r))
        else $error("skip or jump changed zero flag");

    chk_simple_one_cycle: assert property (
        ex_simple |=> !flush_r && pc_r == $past(pc_r) + 13'h0001)
        else $error("simple instruction took more than one cycle");

    chk_skip_acc_dest: assert property (
        ex_skip && !ir_r[DEST_BIT] |=> acc_r == $past(fval) + 8'h01)
        else $error("increment-skip to accumulator wrong");

    // A legal register-port write in the same cycle lands, so it is left out
    chk_skip_file_acc_kept: assert property (
        ex_skip && ir_r[DEST_BIT] && !(bus.wr && bus.addr == ADDR_ACC) |=> $stable(acc_r))
        else $error("increment-skip to file changed accumulator");

    chk_skip_seq_pc: assert property (
        ex_skip |=> pc_r == $past(pc_r) + 13'h0001)
        else $error("increment-skip disturbed the fetch order");

    chk_flush_acc_kept: assert property (
        run && flush_r && !(bus.wr && bus.addr == ADDR_ACC) |=> $stable(acc_r))
        else $error("flushed word changed accumulator");

    chk_flush_zero_kept: assert property (
        run && flush_r && !(bus.wr && bus.addr == ADDR_STATUS) |=> $stable(zero_r))
        else $error("flushed word changed zero flag");

    chk_jump_one_flush: assert property (
        ex_jump |=> 1'b1 ##1 (!flush_r || !run))
        else $error("jump flushed more than one word");

    chk_jump_acc_kept: assert property (
        ex_jump && !(bus.wr && bus.addr == ADDR_ACC) |=> $stable(acc_r))
        else $error("jump changed accumulator");

    chk_or_literal_zero: assert property (
        exec_en && dec.op == CPUIJ_OP_OR_LIT
        |=> zero_r == (($past(acc_r) | $past(ir_r[DW-1:0])) == 8'h00))
        else $error("or-literal zero flag wrong");

    chk_or_literal_no_file: assert property (
        exec_en && dec.op == CPUIJ_OP_OR_LIT |-> dec.to_acc && !dec.to_file)
        else $error("or-literal did not target accumulator");

    chk_incr_file_dest: assert property (
        exec_en && dec.op == CPUIJ_OP_INCR && ir_r[DEST_BIT]
        |=> file_mem[$past(faddr)] == $past(fval) + 8'h01)
        else $error("increment to file register wrong");

    chk_incr_zero: assert property (
        exec_en && dec.op == CPUIJ_OP_INCR
        |=> zero_r == ($past(fval) == 8'hff))
        else $error("increment zero flag wrong");

    chk_or_reg_file: assert property (
        exec_en && dec.op == CPUIJ_OP_OR_REG && ir_r[DEST_BIT]
        |=> file_mem[$past(faddr)] == ($past(acc_r) | $past(fval)))
        else $error("or-register to file register wrong");

    chk_or_reg_zero: assert property (
        exec_en && dec.op == CPUIJ_OP_OR_REG
        |=> zero_r == (($past(acc_r) | $past(fval)) == 8'h00))
        else $error("or-register zero flag wrong");

    chk_move_file_same: assert property (
        exec_en && dec.op == CPUIJ_OP_MOVE && ir_r[DEST_BIT]
        |=> file_mem[$past(faddr)] == $past(fval))
        else $error("move to itself changed the register");

    // Halted core: nothing fetches or executes, the port still answers
    chk_halt_pc_held: assert property (
        !run |=> $stable(pc_r))
        else $error("program counter moved while halted");

    chk_halt_acc_held: assert property (
        !run && !(bus.wr && bus.addr == ADDR_ACC) |=> $stable(acc_r))
        else $error("accumulator changed while halted");

    chk_rdata_idle: assert property (
        !bus.rd |=> bus_rdata == 8'h00)
        else $error("read data shown without a read strobe");

    chk_rdata_acc: assert property (
        bus.rd && bus.addr == ADDR_ACC |=> bus_rdata == $past(acc_r))
        else $error("accumulator read returned wrong data");

    cov_skip_taken: cover property (ex_skip && fval == 8'hff);
    cov_jump: cover property (ex_jump ##2 exec_en);
    cov_move_to_file: cover property (exec_en && dec.op == CPUIJ_OP_MOVE && ir_r[DEST_BIT]);
    cov_or_zero: cover property (exec_en && dec.upd_z && dec.result == 8'h00);
    cov_skip_kept: cover property (ex_skip && fval != 8'hff);

endmodule // cpuij_core

// [dv/cpuij_prog_mem.sv]
// Program memory model answering the core's fetch address in the same cycle
`timescale 1ns/10ps
module cpuij_prog_mem (
    input wire logic [cpuij_pkg::PCW-1:0] prog_addr,
    output logic [cpuij_pkg::IW-1:0] prog_data
);
    import cpuij_pkg::*;
    // Bench loads words directly; empty places read as no_operation
    logic [IW-1:0] mem [0:(1<<PCW)-1];
    initial begin
        for (int i = 0; i < (1 << PCW); i++) begin
            mem[i] = INSTR_NO_OPERATION;
        end
    end
    // Combinational read, as the core expects the word beside its address
    assign prog_data = mem[prog_addr];
endmodule // cpuij_prog_mem

// [dv/test_cpu_incr_or_move_jump_exec.sv]
// Self-checking bench: runs short programs, then checks state over the register port
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module test_cpu_incr_or_move_jump_exec;
    import cpuij_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    cpuij_bus_t bus = '0;
    logic [DW-1:0] bus_rdata;
    logic [IW-1:0] prog_data;
    logic [PCW-1:0] prog_addr;
    logic [DW-1:0] acc_out;
    logic zero_out;
    int fail_count = 0;
    int total_checks = 0;
    int ptr;
    int seed_dummy;
    logic [DW-1:0] exp_q [$];
    logic [DW-1:0] e_now;
    logic rd_d = 1'b0;
    logic [BAW-1:0] rd_addr_d = '0;
    logic [DW-1:0] v, w, a, k, r;

    always #50 clk_sys = ~clk_sys;

    cpuij_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
        .prog_data(prog_data), .prog_addr(prog_addr), .acc_out(acc_out), .zero_out(zero_out));
    cpuij_prog_mem i_mem (.prog_addr(prog_addr), .prog_data(prog_data));

    function automatic logic [IW-1:0] enc_fr(input logic [5:0] o, input logic d,
        input logic [6:0] f);
        return {o, d, f};
    endfunction
    function automatic logic [IW-1:0] enc_lit(input logic [7:0] kv);
        return {OPC_OR_LIT, kv};
    endfunction

    task automatic bus_op(input logic [BAW-1:0] ad, input logic [DW-1:0] d,
        input logic wi, input logic ri);
        @(posedge clk_sys);
        bus <= '{addr: ad, wdata: d, wr: wi, rd: ri};
    endtask
    task automatic wr(input logic [BAW-1:0] ad, input logic [DW-1:0] d);
        bus_op(ad, d, 1'b1, 1'b0);
    endtask
    // The expected value is noted before the strobe goes out
    task automatic rd(input logic [BAW-1:0] ad, input logic [DW-1:0] e);
        exp_q.push_back(e);
        bus_op(ad, 8'h00, 1'b0, 1'b1);
    endtask
    task automatic begin_test();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < (1 << PCW); i++) begin
            i_mem.mem[i] = INSTR_NO_OPERATION;
        end
        // Leading no-ops leave room for the setup writes
        ptr = 8;
    endtask
    task automatic put(input logic [IW-1:0] word);
        i_mem.mem[ptr] = word;
        ptr++;
    endtask
    task automatic go();
        @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask
    task automatic stop_run();
        bus_op(8'h00, 8'h00, 1'b0, 1'b0);
        repeat (ptr + 2) @(posedge clk_sys);
        wr(ADDR_CTRL, 8'h00);
    endtask
    task automatic end_test(input string name);
        bus_op(8'h00, 8'h00, 1'b0, 1'b0);
        repeat (3) @(posedge clk_sys);
        $display("test %s done", name);
    endtask
    task final_report();
        // Notes never taken off the queue mean a read answer went missing
        if (exp_q.size() != 0) begin
            fail_count++;
        end
        $display("checks=%0d fails=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_d) begin
            e_now = exp_q.pop_front();
            `CHK(bus_rdata, e_now)
            if (rd_addr_d == ADDR_ACC) begin
                `CHK(acc_out, e_now)
            end
            if (rd_addr_d == ADDR_STATUS) begin
                `CHK(zero_out, e_now[STATUS_Z_BIT])
            end
            if (rd_addr_d == ADDR_PC_HIGH) begin
                `CHK(prog_addr[PCW-1:DW], e_now[PCW-DW-1:0])
            end
        end
        rd_d <= bus.rd;
        rd_addr_d <= bus.addr;
    end

    initial begin
        #2000000;
        fail_count++;
        final_report();
    end

    initial begin
        seed_dummy = $urandom(93844);
        repeat (6) @(posedge clk_sys);
        // Increment-skip, nonzero result: next word runs
        begin_test();
        v = 8'($urandom_range(254, 0));
        k = 8'($urandom);
        put(enc_fr(OPC_INCR_SKIP, 1'b0, 7'h05));
        put(enc_lit(k));
        go();
        wr(ADDR_STATUS, 8'h01);
        wr(8'h05, v);
        stop_run();
        rd(ADDR_ACC, (v + 8'h01) | k);
        rd(8'h05, v);
        rd(ADDR_STATUS, 8'h00);
        end_test("skip_not_taken");
        // Increment-skip reaching zero: following word dropped, flags kept
        begin_test();
        v = 8'($urandom_range(254, 0));
        a = 8'($urandom) & 8'ha5;
        put(enc_fr(OPC_INCR_SKIP, 1'b1, 7'h06));
        put(enc_lit(8'h5a));
        put(enc_fr(OPC_INCR_SKIP, 1'b1, 7'h0c));
        go();
        wr(ADDR_STATUS, 8'h01);
        wr(ADDR_ACC, a);
        wr(8'h06, 8'hff);
        wr(8'h0c, v);
        stop_run();
        rd(8'h06, 8'h00);
        rd(ADDR_ACC, a);
        rd(8'h0c, v + 8'h01);
        rd(ADDR_STATUS, 8'h01);
        end_test("skip_taken");
        // Jump into the upper page; fetched word after it is flushed
        begin_test();
        k = 8'($urandom) & 8'h7f;
        put({OPC_JUMP, 11'h100});
        put(enc_lit(8'h80));
        i_mem.mem[13'h1900] = enc_lit(k);
        go();
        wr(ADDR_ACC, 8'h00);
        wr(ADDR_PC_LATCH, 8'h1f);
        stop_run();
        rd(ADDR_ACC, k);
        wr(ADDR_PC_HIGH, 8'hff);
        rd(ADDR_PC_HIGH, 8'h19);
        rd(ADDR_PC_LOW, 8'h07);
        rd(ADDR_PC_LATCH, 8'h1f);
        rd(ADDR_STATUS, {7'h00, k == 8'h00});
        rd(8'h90, 8'h00);
        end_test("jump");
        // Chained increment and or-register, each one cycle; first pass fixed operands with zero results, then random operands
        for (int n = 0; n < 4; n++) begin
            begin_test();
            v = 8'($urandom);
            w = 8'($urandom);
            a = (n == 0) ? 8'h00 : 8'($urandom);
            if (n == 0) begin
                v = 8'hff;
                w = 8'h00;
            end
            r = w | a | (v + 8'h01);
            put(enc_fr(OPC_INCR_REG, 1'b1, 7'h07));
            put(enc_fr(OPC_OR_ACC_REG, 1'b0, 7'h07));
            put(enc_fr(OPC_OR_ACC_REG, 1'b1, 7'h08));
            go();
            wr(ADDR_ACC, a);
            wr(8'h07, v);
            wr(8'h08, w);
            stop_run();
            rd(8'h07, v + 8'h01);
            rd(ADDR_ACC, a | (v + 8'h01));
            rd(8'h08, r);
            rd(ADDR_STATUS, {7'h00, r == 8'h00});
            end_test("incr_or_reg");
        end
        // Zero results, moves both ways, zero flag from a self-move
        begin_test();
        k = 8'($urandom) | 8'h01;
        put(enc_fr(OPC_INCR_REG, 1'b0, 7'h0a));
        put(enc_lit(8'h00));
        put(enc_fr(OPC_MOVE_REG, 1'b0, 7'h0b));
        put(enc_fr(OPC_MOVE_REG, 1'b1, 7'h09));
        go();
        wr(8'h09, 8'h00);
        wr(8'h0a, 8'hff);
        wr(8'h0b, k);
        stop_run();
        rd(ADDR_ACC, k);
        rd(8'h09, 8'h00);
        rd(8'h0a, 8'hff);
        rd(ADDR_STATUS, 8'h01);
        end_test("move_zero");
        final_report();
    end
endmodule // test_cpu_incr_or_move_jump_exec
